// ---- master_clock_consts.svh ----
// Constants of the master clocking unit: offsets, fields, resets, fixed divider.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MASTER_CLOCK_CONSTS_SVH
`define MASTER_CLOCK_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_DIV_LOW 12'h004
`define OFS_DIV_HIGH 12'h008
`define OFS_STATUS 12'h00c
`define OFS_PORT_BASE 12'h010

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define CTRL_FLEX_BIT 0
`define DIV_LOW_W 6
`define DIV_HIGH_W 5
`define DIV_W 11
`define PCFG_RXC_LSB 0
`define PCFG_RXD_BIT 2
`define PCFG_TXC_LSB 3
`define PCFG_TXD_BIT 5
`define PCFG_T1_BIT 6
`define ST_RESET_BIT 16
`define ST_CLKU_BIT 17
`define ST_SERIAL_BIT 18
`define ST_CNT_LSB 24

// ------------------------------------------------------------
// Reset values and fixed-mode divider
// ------------------------------------------------------------
`define RST_FLEX 1'b1
`define RST_DIV_LOW 6'h00
`define RST_DIV_HIGH 5'h00
`define RST_PCFG 7'h00
`define FIXED_DIV_LOW 6'h23
`define FIXED_DIV_HIGH 5'h02
`define HOST_IF_PARALLEL 2'h0
`define NUM_PORTS 4

`endif

// ---- master_clock_pkg.sv ----
// Types of the master clocking unit.
// Assumes master_clock_consts.svh is on the include path.
package master_clock_pkg;
   `include "master_clock_consts.svh"

   typedef enum logic [1:0] {
      CODE_NRZ = 2'b00,
      CODE_CMI = 2'b01,
      CODE_AMI = 2'b10,
      CODE_HDB3 = 2'b11
   } line_code_t;

   typedef enum logic [1:0] {
      FMT_DUAL = 2'b00,
      FMT_VIOL = 2'b01,
      FMT_AMI_ERR = 2'b10,
      FMT_NRZ_MARK = 2'b11
   } framer_fmt_t;
endpackage : master_clock_pkg

// ---- rail_code_decode.sv ----
// Per-port decode of line code and rail selection into framer pin usage.
// Assumes a single clock and synchronous active-low reset.
module rail_code_decode
   import master_clock_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] rx_code_select,
   input wire logic rx_dual_rail_sel,
   input wire logic [1:0] tx_code_select,
   input wire logic tx_dual_rail_sel,
   output framer_fmt_t rx_fmt,
   output framer_fmt_t tx_fmt
);
   function automatic framer_fmt_t fmt_of(input logic [1:0] code, input logic dual, input logic is_tx);
      framer_fmt_t f;
      f = FMT_DUAL;
      case (line_code_t'(code))
         CODE_NRZ: f = (is_tx || !dual) ? FMT_NRZ_MARK : FMT_DUAL;
         CODE_AMI: f = dual ? FMT_DUAL : FMT_AMI_ERR;
         CODE_HDB3, CODE_CMI: f = dual ? FMT_DUAL : FMT_VIOL;
         default: f = FMT_DUAL;
      endcase
      return f;
   endfunction : fmt_of

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rx_fmt <= FMT_NRZ_MARK;
         tx_fmt <= FMT_NRZ_MARK;
      end else begin
         rx_fmt <= fmt_of(rx_code_select, rx_dual_rail_sel, 1'b0);
         tx_fmt <= fmt_of(tx_code_select, tx_dual_rail_sel, 1'b1);
      end
   end
endmodule : rail_code_decode

// ---- master_clock_pll_control.sv ----
// Master clocking unit control: PLL divider selection, PLL and clock-unit resets,
// APB register slave, per-port rate and framer format selection.
// Assumes APB master on mclk; strap pins and mode select synchronous to mclk.
//
// Added by the designer: the address map and the APB slave port.
`include "master_clock_consts.svh"

// Functional notes
// - Flex enable one: host programs dividers
// - Flex mode: per-port E1/T1 choice
// - Reset leaves unit in flexible mode
// - Fixed mode: internal dividers, ports common
// - Parallel flex: divider change resets PLL
// - E1/T1 switch resets clock unit only
// - Parallel fixed: divider writes never reset
// - Serial flex: straps set divider, change resets
// - Fixed mode ignores divider registers and straps; port 0 register sets the common rate, each port register its format
// - Reset forces PLL reset and flex
// - Flex toggle resets if divider differs fixed
// - Each PLL reset resets clock system
// - Straps share register divider encoding
// - Code select and rail bit encoding
// - Framer pins usage per mode
module master_clock_pll_control
   import master_clock_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] host_if_select,
   input wire logic [10:0] strap_pins,
   output logic pll_reset,
   output logic clk_unit_reset,
   output logic [10:0] pll_divider,
   output logic flex_freq_enable,
   output logic [3:0] port_t1_mode,
   output logic [7:0] rx_framer_fmt,
   output logic [7:0] tx_framer_fmt
);
   localparam logic [10:0] FIXED_DIV = {`FIXED_DIV_HIGH, `FIXED_DIV_LOW};

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic flex_r;
   logic [5:0] pll_divider_reg_low;
   logic [4:0] pll_divider_reg_high;
   logic [6:0] port_cfg_r [`NUM_PORTS];
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic pll_reset_r;
   logic clk_unit_reset_r;
   logic [10:0] pll_divider_r;
   logic [3:0] port_t1_r;
   logic [10:0] strap_prev_r;
   logic strap_seen_r;
   logic [7:0] pll_reset_cnt_r;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   function automatic logic [3:0] reg_index(input logic [11:0] a);
      logic [3:0] idx;
      idx = 4'hf;
      if (a[1:0] == 2'h0 && a[11:5] == 7'h00) begin
         idx = {1'b0, a[4:2]};
      end
      return idx;
   endfunction : reg_index

   logic access;
   logic wr_en;
   logic [3:0] widx;
   logic serial_mode;
   logic [10:0] reg_div;
   logic [10:0] new_reg_div;
   logic div_write_change;
   logic flex_wr;
   logic flex_toggle;
   logic strap_change;
   logic pll_trig;
   logic [3:0] t1_nxt;

   assign access = psel && penable;
   assign wr_en = access && pready_r && pwrite;
   assign widx = reg_index(paddr);
   assign serial_mode = (host_if_select != `HOST_IF_PARALLEL);
   assign reg_div = {pll_divider_reg_high, pll_divider_reg_low};
   assign new_reg_div = (widx == 4'h1) ? {pll_divider_reg_high, pwdata[5:0]} :
                        (widx == 4'h2) ? {pwdata[4:0], pll_divider_reg_low} : reg_div;
   assign flex_wr = wr_en && (widx == 4'h0);
   assign flex_toggle = flex_wr && (pwdata[`CTRL_FLEX_BIT] != flex_r);
   // only a changing write in flexible parallel mode counts
   assign div_write_change = wr_en && !serial_mode && flex_r && (new_reg_div != reg_div);
   // strap changes count in serial flexible mode only
   assign strap_change = serial_mode && flex_r && strap_seen_r && (strap_pins != strap_prev_r);
   // toggle resets only when the active divider would differ from fixed
   assign pll_trig = div_write_change || strap_change ||
                     (flex_toggle && ((serial_mode ? strap_pins : reg_div) != FIXED_DIV));

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= access && !pready_r;
         pslverr_r <= access && !pready_r && (widx == 4'hf);
         if (access && !pready_r) begin
            case (widx)
               4'h0: prdata_r <= {31'h00000000, flex_r};
               4'h1: prdata_r <= {26'h0000000, pll_divider_reg_low};
               4'h2: prdata_r <= {27'h0000000, pll_divider_reg_high};
               4'h3: prdata_r <= {pll_reset_cnt_r, 5'h00, serial_mode, clk_unit_reset_r,
                                  pll_reset_r, 5'h00, pll_divider_r};
               4'h4, 4'h5, 4'h6, 4'h7: prdata_r <= {25'h0000000, port_cfg_r[widx[1:0]]};
               default: prdata_r <= 32'h00000000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         flex_r <= `RST_FLEX;
      end else if (flex_wr) begin
         flex_r <= pwdata[`CTRL_FLEX_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pll_divider_reg_low <= `RST_DIV_LOW;
         pll_divider_reg_high <= `RST_DIV_HIGH;
      end else if (wr_en) begin
         if (widx == 4'h1) begin
            pll_divider_reg_low <= pwdata[5:0];
         end
         if (widx == 4'h2) begin
            pll_divider_reg_high <= pwdata[4:0];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_PORTS; gi++) begin : g_port
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               port_cfg_r[gi] <= `RST_PCFG;
            end else if (wr_en && widx == 4'(gi + 4)) begin
               port_cfg_r[gi] <= pwdata[6:0];
            end
         end

         // flexible: own choice; fixed: port 0 sets all
         assign t1_nxt[gi] = flex_r ? port_cfg_r[gi][`PCFG_T1_BIT] : port_cfg_r[0][`PCFG_T1_BIT];

         rail_code_decode u_dec (
            .mclk(mclk),
            .reset_n(reset_n),
            .rx_code_select(port_cfg_r[gi][1:0]),
            .rx_dual_rail_sel(port_cfg_r[gi][`PCFG_RXD_BIT]),
            .tx_code_select(port_cfg_r[gi][4:3]),
            .tx_dual_rail_sel(port_cfg_r[gi][`PCFG_TXD_BIT]),
            .rx_fmt(rx_framer_fmt[2*gi +: 2]),
            .tx_fmt(tx_framer_fmt[2*gi +: 2])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Strap tracking
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         strap_prev_r <= 11'h000;
         strap_seen_r <= 1'b0;
      end else begin
         strap_prev_r <= strap_pins;
         strap_seen_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Divider, PLL reset and clock-unit reset
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pll_divider_r <= FIXED_DIV;
      end else if (!flex_r) begin
         pll_divider_r <= FIXED_DIV;
      end else begin
         pll_divider_r <= serial_mode ? strap_pins : reg_div;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pll_reset_r <= 1'b1;
      end else begin
         pll_reset_r <= pll_trig;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         port_t1_r <= 4'h0;
         clk_unit_reset_r <= 1'b1;
      end else begin
         port_t1_r <= t1_nxt;
         clk_unit_reset_r <= pll_trig || (t1_nxt != port_t1_r);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pll_reset_cnt_r <= 8'h00;
      end else if (pll_trig) begin
         pll_reset_cnt_r <= pll_reset_cnt_r + 8'h01;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pll_reset = pll_reset_r;
   assign clk_unit_reset = clk_unit_reset_r;
   assign pll_divider = pll_divider_r;
   assign flex_freq_enable = flex_r;
   assign port_t1_mode = port_t1_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence div_change_write_s;
      wr_en && !serial_mode && flex_r && (new_reg_div != reg_div);
   endsequence

   sequence strap_moved_s;
      serial_mode && flex_r && strap_seen_r && (strap_pins != strap_prev_r);
   endsequence

   sequence toggle_unfixed_s;
      flex_toggle && !serial_mode && (reg_div != FIXED_DIV);
   endsequence

   after_reset_flex_a: assert property ($rose(reset_n) |-> flex_freq_enable && pll_reset)
      else $error("reset did not force flex and PLL reset");
   div_write_reset_a: assert property (div_change_write_s |=> pll_reset ##0 clk_unit_reset)
      else $error("divider change gave no PLL reset");
   fixed_no_reset_a: assert property (wr_en && !serial_mode && !flex_r && !flex_wr |=> !pll_reset)
      else $error("fixed mode write reset the PLL");
   strap_pulse_a: assert property (strap_moved_s ##1 ($stable(strap_pins) && !wr_en) |->
      pll_reset ##1 !pll_reset)
      else $error("strap change not a single pulse");
   fixed_divider_a: assert property (!flex_r |=> pll_divider == FIXED_DIV)
      else $error("fixed mode divider wrong");
   serial_divider_a: assert property (serial_mode && flex_r && !flex_wr |=> pll_divider == $past(strap_pins))
      else $error("strap divider not applied");
   pll_clk_reset_a: assert property (pll_reset |-> clk_unit_reset)
      else $error("PLL reset without clock unit reset");
   rate_switch_a: assert property (!pll_trig && t1_nxt != port_t1_r |=> clk_unit_reset && !pll_reset)
      else $error("rate switch reset handling wrong");
   toggle_same_a: assert property (flex_toggle && !serial_mode && reg_div == FIXED_DIV |=> !pll_reset)
      else $error("toggle at fixed divider reset the PLL");
   fixed_common_a: assert property (!flex_r |=> port_t1_mode == {4{$past(port_cfg_r[0][`PCFG_T1_BIT])}})
      else $error("fixed mode ports not common");
   serial_write_a: assert property (wr_en && serial_mode && !flex_wr && $stable(strap_pins) |=> !pll_reset)
      else $error("divider write reset the PLL in serial mode");
   flex_divider_a: assert property (!serial_mode && flex_r && !flex_wr |=> pll_divider == $past(reg_div))
      else $error("register divider not applied");
   toggle_differ_a: assert property (toggle_unfixed_s |=> pll_reset && clk_unit_reset)
      else $error("toggle at other divider gave no PLL reset");
   ami_single_a: assert property (port_cfg_r[0][1:0] == CODE_AMI && !port_cfg_r[0][`PCFG_RXD_BIT] |=>
      rx_framer_fmt[1:0] == FMT_AMI_ERR)
      else $error("single rail AMI format wrong");
   rx_dual_a: assert property (port_cfg_r[0][`PCFG_RXD_BIT] |=> rx_framer_fmt[1:0] == FMT_DUAL)
      else $error("receive dual rail format wrong");
   tx_nrz_mark_a: assert property (port_cfg_r[0][4:3] == CODE_NRZ |=> tx_framer_fmt[1:0] == FMT_NRZ_MARK)
      else $error("transmit NRZ frame marker format wrong");
endmodule : master_clock_pll_control

// ---- host_strap_model.sv ----
// Partner model: host-side interface mode select and divider strap pins.
// Assumes the bench clock runs from time zero, before reset is released.
module host_strap_model (
   input wire logic mclk,
   input wire logic [1:0] mode_req,
   input wire logic [10:0] strap_req,
   output logic [1:0] host_if_select,
   output logic [10:0] strap_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pins follow the host request one edge later, reference already running
   always_ff @(posedge mclk) begin
      host_if_select <= mode_req;
      strap_pins <= strap_req;
   end
endmodule : host_strap_model

// ---- test_master_clock_pll_control.sv ----
// Testbench of the master clocking unit: APB accesses, strap changes, pulse counts.
// Assumes the package and constants header of the design are compiled first.
`include "master_clock_consts.svh"
module test_master_clock_pll_control
   import master_clock_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [10:0] FIXED_DIV = {`FIXED_DIV_HIGH, `FIXED_DIV_LOW};
   logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, er, pll_reset, clk_unit_reset, flex_freq_enable, rail;
   logic [1:0] host_if_select, mode_req = 0, code;
   logic [10:0] strap_pins, pll_divider, strap_req = FIXED_DIV;
   logic [3:0] port_t1_mode;
   logic [7:0] rx_framer_fmt, tx_framer_fmt;
   framer_fmt_t fe;
   int fail_count = 0, checked = 0, pll_n = 0, clku_n = 0, p0, c0;

   master_clock_pll_control dut_u (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_if_select(host_if_select), .strap_pins(strap_pins),
      .pll_reset(pll_reset), .clk_unit_reset(clk_unit_reset), .pll_divider(pll_divider),
      .flex_freq_enable(flex_freq_enable), .port_t1_mode(port_t1_mode),
      .rx_framer_fmt(rx_framer_fmt), .tx_framer_fmt(tx_framer_fmt));
   host_strap_model host_u (.mclk(mclk), .mode_req(mode_req), .strap_req(strap_req),
      .host_if_select(host_if_select), .strap_pins(strap_pins));

   always #4 mclk = ~mclk;
   // Pulse counters
   always @(posedge mclk) begin
      if (reset_n === 1'b1 && pll_reset === 1'b1) pll_n++;
      if (reset_n === 1'b1 && clk_unit_reset === 1'b1) clku_n++;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task final_report;
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chk

   task chk_cnt(input int got, input int exp);
      checked++;
      if (got != exp) begin
         fail_count++;
         $display("mismatch at %0t: %0d pulses expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         $display("mismatch at %0t: no pready", $time);
         fail_count++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task settle;
      repeat (4) @(posedge mclk);
   endtask : settle

   task wr(input logic [11:0] a, input logic [31:0] d);
      p0 = pll_n;
      c0 = clku_n;
      apb(1, a, d);
      settle();
   endtask : wr

   task do_reset;
      reset_n <= 0;
      repeat (12) @(posedge mclk);
      chk({pll_reset, clk_unit_reset, flex_freq_enable}, 3'b111);
      reset_n <= 1;
      settle();
   endtask : do_reset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      do_reset();
      apb(0, `OFS_CTRL, 0);
      chk(rd[0], 1);
      wr(`OFS_DIV_LOW, 32'h10);
      chk_cnt(pll_n - p0, 1);
      chk_cnt(clku_n - c0, 1);
      chk(pll_divider, 11'h010);
      wr(`OFS_DIV_LOW, 32'h10);
      chk_cnt(pll_n - p0, 0);
      wr(`OFS_DIV_HIGH, 32'h1);
      chk_cnt(pll_n - p0, 1);
      chk(pll_divider, 11'h050);
      wr(`OFS_PORT_BASE + 12'h8, 32'h40);
      chk(port_t1_mode, 4'h4);
      chk_cnt(pll_n - p0, 0);
      chk_cnt(clku_n - c0, 1);
      for (int i = 0; i < 8; i++) begin
         code = i[1:0];
         rail = i[2];
         wr(`OFS_PORT_BASE, {26'h0, rail, code, rail, code});
         fe = rail ? FMT_DUAL : (code == CODE_AMI) ? FMT_AMI_ERR : (code == CODE_NRZ) ? FMT_NRZ_MARK : FMT_VIOL;
         chk(rx_framer_fmt[1:0], fe);
         chk(tx_framer_fmt[1:0], (code == CODE_NRZ) ? FMT_NRZ_MARK : fe);
      end
      apb(0, 12'h020, 0);
      chk({er, rd[30:0]}, 32'h80000000);
      wr(`OFS_CTRL, 0);
      chk(flex_freq_enable, 0);
      chk_cnt(pll_n - p0, 1);
      chk(pll_divider, FIXED_DIV);
      wr(`OFS_DIV_LOW, 32'h23);
      chk_cnt(pll_n - p0, 0);
      chk(pll_divider, FIXED_DIV);
      wr(`OFS_PORT_BASE, 32'h40);
      chk(port_t1_mode, 4'hf);
      chk_cnt(pll_n - p0, 0);
      chk_cnt(clku_n - c0, 1);
      wr(`OFS_DIV_HIGH, `FIXED_DIV_HIGH);
      chk_cnt(pll_n - p0, 0);
      wr(`OFS_CTRL, 1);
      chk_cnt(pll_n - p0, 0);
      chk(pll_divider, FIXED_DIV);
      do_reset();
      chk(flex_freq_enable, 1);
      mode_req <= 2'h1;
      settle();
      apb(0, `OFS_STATUS, 0);
      chk(rd[18], 1);
      p0 = pll_n;
      strap_req <= 11'h155;
      settle();
      chk_cnt(pll_n - p0, 1);
      chk(pll_divider, 11'h155);
      wr(`OFS_DIV_LOW, 32'h3f);
      chk_cnt(pll_n - p0, 0);
      chk(pll_divider, 11'h155);
      final_report();
   end
endmodule : test_master_clock_pll_control
